// File: core/frame_timing_pkg.sv
// Functional notes
// - four taps, 80 MHz strobe, full frame: frame rate accepted 1 to 60.4 Hz
// - two taps, 80 MHz strobe, full frame: frame rate accepted 1 to 30.6 Hz
// - fewer window rows shorten readout and so raise the top rate limit
// - rate limits follow strobe, taps, snapshot mode, dump count, rows
// - rate and exposure commands act only in exposure mode 2
// - new rate too short for exposure: shorten exposure, raise warning
// - exposure accepted as a value from 10 to 999989 us
// - exposure outside range is rejected, old exposure kept
// - overlapping exposure in mode 2 rounds silently to whole increments
// - exposure longer than frame period lowers frame rate with warning
// - link modes 15/16: increment 18.513 us on overlap, else 1 us
// - link modes 2/3 on overlap: 37.038 us at 80 MHz, 45.638 us at 65 MHz
// - same increments govern trigger modes 4 and 6 during overlap
// - trigger falling edge is sampled once per increment
// - trigger modes may deviate from trigger timing by one increment
// - current rate limits are reported while in mode 2
// - mode 2 makes frame and exposure timing internally, the default mode
// - frame period never shorter than the readout period; only mode 2 enforces it, mode 4 starts a frame on each trigger fall, mode 6 when exposure ends
// - mode 4: trigger rise starts exposure, fall starts readout
// - mode 6: trigger fall launches programmed exposure
package frame_timing_pkg;
  localparam logic [31:0] NS_STEP = 32'h0000_0032;
  localparam logic [39:0] NS_MHZ_NUM = 40'he8_d4a5_1000;
  localparam logic [31:0] MAX_PERIOD_NS = 32'h3b9a_ca00;
  localparam logic [31:0] EXPO_MIN_NS = 32'h0000_2710;
  localparam logic [31:0] EXPO_MAX_NS = 32'h3b9a_a2c8;
  localparam logic [31:0] INC_CLM_HI_NS = 32'h0000_4851;
  localparam logic [31:0] INC_CLM_LO_80_NS = 32'h0000_90ae;
  localparam logic [31:0] INC_CLM_LO_65_NS = 32'h0000_b246;
  localparam logic [31:0] INC_FREE_NS = 32'h0000_03e8;
  localparam logic [15:0] LINE_NS_4T_80 = 16'h1b7f;
  localparam logic [15:0] LINE_NS_4T_65 = 16'h21d8;
  localparam logic [15:0] LINE_NS_2T_80 = 16'h3646;
  localparam logic [15:0] LINE_NS_2T_65 = 16'h42cc;
  localparam logic [19:0] DUMP_NS = 20'h7_704c;
  localparam logic [31:0] DEF_PERIOD_NS = 32'h01fc_a055;
  localparam logic [31:0] DEF_EXPO_NS = 32'h0098_9680;
  localparam logic [4:0] CLM_HI_A = 5'h0f;
  localparam logic [4:0] CLM_HI_B = 5'h10;
  localparam logic [4:0] CLM_LO_A = 5'h02;
  localparam logic [4:0] CLM_LO_B = 5'h03;
  localparam logic [2:0] MODE_INT = 3'h2;
  localparam logic [2:0] MODE_SMART = 3'h4;
  localparam logic [2:0] MODE_EXT_RATE = 3'h6;
  localparam logic [1:0] SNAP_NO_OVERLAP = 2'h2;
  localparam logic [5:0] DIV_STEPS = 6'h28;
  typedef enum logic {CMD_RATE, CMD_EXPO} cmd_kind_e;
  typedef struct packed {
    cmd_kind_e kind;
    logic [31:0] value;
  } cmd_s;
  typedef struct packed {
    logic [31:0] min_period_ns;
    logic [31:0] max_period_ns;
  } lim_s;
endpackage : frame_timing_pkg

// File: core/frame_rate_exposure_timing.sv
`timescale 1ns/1ns
module frame_rate_exposure_timing (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic cmd_valid_i,
  input frame_timing_pkg::cmd_s cmd_i,
  input wire logic [2:0] exp_mode_i,
  input wire logic [4:0] link_mode_i,
  input wire logic strobe_80_i,
  input wire logic taps_4_i,
  input wire logic [1:0] snap_mode_i,
  input wire logic [3:0] dumps_i,
  input wire logic [11:0] rows_i,
  input wire logic trig_i,
  output logic cmd_done_o,
  output logic cmd_err_o,
  output logic warn_o,
  output logic [31:0] period_ns_o,
  output logic [31:0] expo_ns_o,
  output frame_timing_pkg::lim_s lim_o,
  output logic exposure_o,
  output logic readout_o,
  output logic frame_start_o
);
  import frame_timing_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_APPLY} cmd_state_e;
  cmd_state_e state;
  cmd_s cmd;
  logic [39:0] quo;
  logic [39:0] rem;
  logic [39:0] den;
  logic [5:0] steps;
  logic [31:0] cmd_inc;
  logic [31:0] readout_ns;
  logic [31:0] eff_period;
  logic [31:0] frame_ns;
  logic [31:0] rd_ns;
  logic [31:0] ex_ns;
  logic [31:0] tick_ns;
  logic [31:0] ext_inc;
  logic inc_tick;
  logic trig_m;
  logic trig_s;
  logic trig_q;
  logic rd_start;
  logic [15:0] line_ns;
  logic [39:0] rem_sh;
  logic [31:0] rounded;
  logic [63:0] prod;

  function automatic logic [31:0] inc_for(input logic ovl, input logic [4:0] clm, input logic s80);
    logic [31:0] r;
    r = INC_FREE_NS;
    if (ovl && (clm == CLM_HI_A || clm == CLM_HI_B)) begin
      r = INC_CLM_HI_NS;
    end else if (ovl && (clm == CLM_LO_A || clm == CLM_LO_B)) begin
      r = s80 ? INC_CLM_LO_80_NS : INC_CLM_LO_65_NS;
    end
    return r;
  endfunction : inc_for

  // readout time grows with rows and dumps; the rate limit is checked as a period
  always_comb begin
    case ({taps_4_i, strobe_80_i})
      2'b11: line_ns = LINE_NS_4T_80;
      2'b10: line_ns = LINE_NS_4T_65;
      2'b01: line_ns = LINE_NS_2T_80;
      default: line_ns = LINE_NS_2T_65;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      readout_ns <= 32'h0;
    end else begin
      // widen before multiplying; a self-sized product keeps only 16 bits
      readout_ns <= (32'(rows_i) * 32'(line_ns)) + ((snap_mode_i != 2'h0) ? (32'(dumps_i) * 32'(DUMP_NS)) : 32'h0);
    end
  end

  assign eff_period = (period_ns_o < readout_ns) ? readout_ns : period_ns_o;

  // limits as periods: min is readout, max is 1 Hz
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lim_o <= '0;
    end else if (exp_mode_i == MODE_INT) begin
      lim_o.min_period_ns <= readout_ns;
      lim_o.max_period_ns <= MAX_PERIOD_NS;
    end
  end

  assign rem_sh = {rem[38:0], quo[39]};
  assign prod = quo[31:0] * cmd_inc;
  assign rounded = (quo[39:32] != 8'h0 || prod[63:32] != 32'h0) ? EXPO_MAX_NS
                 : (prod[31:0] < cmd_inc) ? cmd_inc : prod[31:0];

  // command engine: one shared divider converts rate to period and exposure to increments
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      cmd <= '0;
      quo <= 40'h0;
      rem <= 40'h0;
      den <= 40'h0;
      steps <= 6'h0;
      cmd_inc <= INC_FREE_NS;
      period_ns_o <= DEF_PERIOD_NS;
      expo_ns_o <= DEF_EXPO_NS;
      cmd_done_o <= 1'b0;
      cmd_err_o <= 1'b0;
      warn_o <= 1'b0;
    end else begin
      cmd_done_o <= 1'b0;
      cmd_err_o <= 1'b0;
      warn_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid_i) begin
            cmd <= cmd_i;
            rem <= 40'h0;
            steps <= DIV_STEPS;
            if (exp_mode_i != MODE_INT) begin
              cmd_err_o <= 1'b1;
            end else if (cmd_i.kind == CMD_RATE) begin
              quo <= NS_MHZ_NUM;
              den <= {8'h0, cmd_i.value};
              state <= ST_DIV;
            end else if (cmd_i.value < EXPO_MIN_NS || cmd_i.value > EXPO_MAX_NS) begin
              cmd_err_o <= 1'b1;
            end else begin
              quo <= {8'h0, cmd_i.value};
              cmd_inc <= inc_for(snap_mode_i != SNAP_NO_OVERLAP && cmd_i.value + readout_ns > eff_period,
                                 link_mode_i, strobe_80_i);
              den <= {8'h0, inc_for(snap_mode_i != SNAP_NO_OVERLAP && cmd_i.value + readout_ns > eff_period,
                                    link_mode_i, strobe_80_i)};
              state <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          if (rem_sh >= den) begin
            rem <= rem_sh - den;
            quo <= {quo[38:0], 1'b1};
          end else begin
            rem <= rem_sh;
            quo <= {quo[38:0], 1'b0};
          end
          steps <= steps - 6'h1;
          if (steps == 6'h1) begin
            state <= ST_APPLY;
          end
        end
        ST_APPLY: begin
          state <= ST_IDLE;
          if (cmd.kind == CMD_RATE) begin
            if (quo > {8'h0, MAX_PERIOD_NS} || quo[31:0] < readout_ns) begin
              cmd_err_o <= 1'b1;
            end else begin
              period_ns_o <= quo[31:0];
              cmd_done_o <= 1'b1;
              if (expo_ns_o > quo[31:0]) begin
                expo_ns_o <= (quo[31:0] > EXPO_MAX_NS) ? EXPO_MAX_NS : quo[31:0];
                warn_o <= 1'b1;
              end
            end
          end else begin
            expo_ns_o <= rounded;
            cmd_done_o <= 1'b1;
            if (rounded > period_ns_o) begin
              period_ns_o <= (rounded < readout_ns) ? readout_ns : rounded;
              warn_o <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // trigger pin crossing
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_m <= 1'b0;
      trig_s <= 1'b0;
    end else begin
      trig_m <= trig_i;
      trig_s <= trig_m;
    end
  end

  // increment tick: ns accumulator so the step tracks the strobe-dependent increment
  assign ext_inc = inc_for(readout_o, link_mode_i, strobe_80_i);
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_ns <= 32'h0;
      inc_tick <= 1'b0;
    end else if (tick_ns + NS_STEP >= ext_inc) begin
      tick_ns <= tick_ns + NS_STEP - ext_inc;
      inc_tick <= 1'b1;
    end else begin
      tick_ns <= tick_ns + NS_STEP;
      inc_tick <= 1'b0;
    end
  end

  // edges are only seen on ticks, so realised exposure is off by up to one increment
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_q <= 1'b0;
    end else if (inc_tick) begin
      trig_q <= trig_s;
    end
  end

  // frame and exposure generation
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_ns <= 32'h0;
      ex_ns <= 32'h0;
      exposure_o <= 1'b0;
      frame_start_o <= 1'b0;
      rd_start <= 1'b0;
    end else begin
      frame_start_o <= 1'b0;
      rd_start <= 1'b0;
      case (exp_mode_i)
        MODE_INT: begin
          if (frame_ns + NS_STEP >= eff_period) begin
            frame_ns <= 32'h0;
            exposure_o <= expo_ns_o >= eff_period;
            frame_start_o <= 1'b1;
            rd_start <= 1'b1;
          end else begin
            frame_ns <= frame_ns + NS_STEP;
            exposure_o <= frame_ns + NS_STEP + expo_ns_o >= eff_period;
          end
        end
        MODE_SMART: begin
          if (inc_tick && trig_s && !trig_q) begin
            exposure_o <= 1'b1;
          end else if (inc_tick && !trig_s && trig_q) begin
            exposure_o <= 1'b0;
            frame_start_o <= 1'b1;
            rd_start <= 1'b1;
          end
        end
        MODE_EXT_RATE: begin
          if (inc_tick && !trig_s && trig_q) begin
            exposure_o <= 1'b1;
            ex_ns <= 32'h0;
          end else if (exposure_o) begin
            if (ex_ns + NS_STEP >= expo_ns_o) begin
              exposure_o <= 1'b0;
              frame_start_o <= 1'b1;
              rd_start <= 1'b1;
            end else begin
              ex_ns <= ex_ns + NS_STEP;
            end
          end
        end
        default: exposure_o <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_ns <= 32'h0;
      readout_o <= 1'b0;
    end else if (rd_start) begin
      rd_ns <= 32'h0;
      readout_o <= 1'b1;
    end else if (readout_o) begin
      rd_ns <= rd_ns + NS_STEP;
      readout_o <= rd_ns + NS_STEP < readout_ns;
    end
  end

  sequence s_cmd_offmode;
    cmd_valid_i && state == ST_IDLE && exp_mode_i != MODE_INT;
  endsequence
  sequence s_err_no_change;
    cmd_err_o && !cmd_done_o && $stable(period_ns_o) && $stable(expo_ns_o);
  endsequence
  property p_mode_gate;
    @(posedge clk_sys_i) disable iff (!rstn_i) s_cmd_offmode |=> s_err_no_change;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("command outside mode 2 not refused");
  property p_expo_reject;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      cmd_valid_i && state == ST_IDLE && exp_mode_i == MODE_INT && cmd_i.kind == CMD_EXPO
      && (cmd_i.value < EXPO_MIN_NS || cmd_i.value > EXPO_MAX_NS) |=> s_err_no_change;
  endproperty
  a_expo_reject: assert property (p_expo_reject) else $error("bad exposure not rejected");
  property p_expo_range;
    @(posedge clk_sys_i) disable iff (!rstn_i) expo_ns_o >= EXPO_MIN_NS && expo_ns_o <= EXPO_MAX_NS;
  endproperty
  a_expo_range: assert property (p_expo_range) else $error("exposure left its range");
  property p_expo_fits;
    @(posedge clk_sys_i) disable iff (!rstn_i) expo_ns_o <= period_ns_o;
  endproperty
  a_expo_fits: assert property (p_expo_fits) else $error("exposure longer than frame period");
  property p_period_floor;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      state == ST_APPLY && cmd.kind == CMD_RATE && quo[31:0] < readout_ns |=> cmd_err_o && $stable(period_ns_o);
  endproperty
  a_period_floor: assert property (p_period_floor) else $error("period below readout accepted");
  property p_warn_done;
    @(posedge clk_sys_i) disable iff (!rstn_i) warn_o |-> cmd_done_o && !cmd_err_o;
  endproperty
  a_warn_done: assert property (p_warn_done) else $error("warning without accepted command");
  property p_inc_hi;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      readout_o && (link_mode_i == CLM_HI_A || link_mode_i == CLM_HI_B) |-> ext_inc == INC_CLM_HI_NS;
  endproperty
  a_inc_hi: assert property (p_inc_hi) else $error("wrong overlap increment");
  property p_fall_on_tick;
    @(posedge clk_sys_i) disable iff (!rstn_i) $fell(trig_q) |-> $past(inc_tick);
  endproperty
  a_fall_on_tick: assert property (p_fall_on_tick) else $error("trigger sampled off tick");
  property p_smart_rise;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      exp_mode_i == MODE_SMART && inc_tick && trig_s && !trig_q |=> exposure_o ##1 (exposure_o || readout_o);
  endproperty
  a_smart_rise: assert property (p_smart_rise) else $error("trigger rise did not start exposure");
  property p_ext_fall;
    @(posedge clk_sys_i) disable iff (!rstn_i)
      exp_mode_i == MODE_EXT_RATE && inc_tick && !trig_s && trig_q |=> exposure_o && ex_ns == 32'h0;
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("trigger fall did not launch exposure");
endmodule : frame_rate_exposure_timing

// File: test/trig_source.sv
`timescale 1ns/1ns
// stands in for the frame grabber driving the external trigger line
module trig_source (
  input wire logic clk_sys_i,
  output logic trig_o
);
  initial trig_o = 1'b0;
  // rise opens exposure in mode 4, fall ends it or launches it in mode 6
  task automatic pulse(input int hi, input int lo);
    @(posedge clk_sys_i);
    trig_o <= 1'b1;
    repeat (hi) @(posedge clk_sys_i);
    trig_o <= 1'b0;
    repeat (lo) @(posedge clk_sys_i);
  endtask : pulse
endmodule : trig_source

// File: test/frame_rate_exposure_timing_tb.sv
`timescale 1ns/1ns
module frame_rate_exposure_timing_tb;
  import frame_timing_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic cmd_valid = 1'b0;
  cmd_s cmd = '0;
  logic [2:0] exp_mode = 3'h2;
  logic [4:0] link_mode = 5'h0f;
  logic strobe_80 = 1'b1;
  logic taps_4 = 1'b1;
  logic [1:0] snap_mode = 2'h1;
  logic [3:0] dumps = 4'h0;
  logic [11:0] rows = 12'h3e8;
  logic trig;
  logic cmd_done, cmd_err, warn, exposure, readout, frame_start;
  logic [31:0] period_ns, expo_ns;
  lim_s lim;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int per, ex, w, rd;

  frame_rate_exposure_timing dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd), .exp_mode_i(exp_mode), .link_mode_i(link_mode), .strobe_80_i(strobe_80),
    .taps_4_i(taps_4), .snap_mode_i(snap_mode), .dumps_i(dumps), .rows_i(rows), .trig_i(trig),
    .cmd_done_o(cmd_done), .cmd_err_o(cmd_err), .warn_o(warn), .period_ns_o(period_ns),
    .expo_ns_o(expo_ns), .lim_o(lim), .exposure_o(exposure), .readout_o(readout),
    .frame_start_o(frame_start));

  trig_source tg (.clk_sys_i(clk_sys_i), .trig_o(trig));

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // a hang in any wait below ends the run here
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk

  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask : step

  // one pulse of valid, then wait for the answer; latency counted from the edge after taking
  task automatic send(input cmd_kind_e k, input logic [31:0] v, input logic ok, input logic wr, input int lat);
    int n;
    @(posedge clk_sys_i);
    cmd_valid <= 1'b1;
    cmd <= '{k, v};
    @(posedge clk_sys_i);
    cmd_valid <= 1'b0;
    n = 0;
    #1;
    while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    chk("latency", lat, n);
    chk("accepted", {31'h0, ok}, {31'h0, cmd_done});
    chk("warning", {31'h0, wr}, {31'h0, warn});
  endtask : send

  // frame length and exposure time of one whole frame, in cycles
  task automatic measure(output int p, output int e, output int r);
    int n;
    n = 0;
    p = 0;
    e = 0;
    r = 0;
    while (frame_start !== 1'b1 && n < 5000) begin
      step();
      n++;
    end
    step();
    while (frame_start !== 1'b1 && p < 5000) begin
      p++;
      if (exposure === 1'b1) e++;
      if (readout === 1'b1) r++;
      step();
    end
    p++;
  endtask : measure

  task automatic width(output int wd);
    int n;
    n = 0;
    wd = 0;
    while (exposure !== 1'b1 && n < 8000) begin
      step();
      n++;
    end
    while (exposure === 1'b1 && wd < 8000) begin
      step();
      wd++;
    end
  endtask : width

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) step();
    chk("period reset", 32'h01fc_a055, period_ns);
    chk("expo reset", 32'h0098_9680, expo_ns);
    chk("lim min", 32'h006b_6818, lim.min_period_ns);
    chk("lim max", 32'h3b9a_ca00, lim.max_period_ns);
    send(CMD_RATE, 32'h0000_61a8, 1'b1, 1'b0, 41);
    chk("period 25hz", 32'h0262_5a00, period_ns);
    send(CMD_RATE, 32'h0, 1'b0, 1'b0, 41);
    send(CMD_RATE, 32'h0000_03e8, 1'b1, 1'b0, 41);
    chk("period 1hz", 32'h3b9a_ca00, period_ns);
    send(CMD_RATE, 32'h0002_49f0, 1'b0, 1'b0, 41);
    chk("period kept", 32'h3b9a_ca00, period_ns);
    send(CMD_RATE, 32'h0001_e848, 1'b1, 1'b1, 41);
    chk("expo shrunk", 32'h007a_1200, expo_ns);
    send(CMD_EXPO, 32'h0000_270f, 1'b0, 1'b0, 0);
    send(CMD_EXPO, 32'h3b9a_a2c9, 1'b0, 1'b0, 0);
    chk("expo kept", 32'h007a_1200, expo_ns);
    send(CMD_EXPO, 32'h0000_2710, 1'b1, 1'b0, 41);
    chk("expo min", 32'h0000_2710, expo_ns);
    send(CMD_EXPO, 32'h0053_ec60, 1'b1, 1'b0, 41);
    chk("expo inc hi", 32'h0053_e5f9, expo_ns);
    link_mode <= 5'h02;
    send(CMD_EXPO, 32'h0053_ec60, 1'b1, 1'b0, 41);
    chk("expo inc 80", 32'h0053_a498, expo_ns);
    strobe_80 <= 1'b0;
    send(CMD_EXPO, 32'h0053_ec60, 1'b1, 1'b0, 41);
    chk("expo inc 65", 32'h0053_90d0, expo_ns);
    strobe_80 <= 1'b1;
    link_mode <= 5'h0f;
    send(CMD_EXPO, 32'h0131_2d00, 1'b1, 1'b1, 41);
    chk("expo long", 32'h0131_15b8, expo_ns);
    chk("period raised", 32'h0131_15b8, period_ns);
    snap_mode <= 2'h2;
    send(CMD_EXPO, 32'h0053_ec60, 1'b1, 1'b0, 41);
    chk("expo no overlap", 32'h0053_ec60, expo_ns);
    snap_mode <= 2'h1;
    exp_mode <= 3'h4;
    send(CMD_RATE, 32'h0000_61a8, 1'b0, 1'b0, 0);
    chk("period mode4", 32'h0131_15b8, period_ns);
    exp_mode <= 3'h2;
    rows <= 12'h1f4;
    repeat (3) step();
    chk("lim window", 32'h0035_b40c, lim.min_period_ns);
    rows <= 12'h00a;
    send(CMD_EXPO, 32'h0000_7530, 1'b1, 1'b0, 41);
    send(CMD_RATE, 32'h0098_9680, 1'b1, 1'b0, 41);
    chk("period short", 32'h0001_86a0, period_ns);
    measure(per, ex, rd);
    chk("frame cycles", 2000, per);
    chk("expo cycles", 600, ex);
    chk("readout cycles", 1408, rd);
    exp_mode <= 3'h6;
    // high for longer than one overlap increment, or no tick may ever see it
    fork
      tg.pulse(400, 4000);
      width(w);
    join
    chk("mode6 width", 600, w);
    exp_mode <= 3'h4;
    fork
      tg.pulse(2000, 3000);
      width(w);
    join
    // the fall is only seen on an increment tick, so allow one overlap increment
    chk("mode4 width", 1, {31'h0, (w >= 1629 && w <= 2371)});
    final_report();
  end
endmodule : frame_rate_exposure_timing_tb
